//--- pulse_train_home_jog_unit.v
/*
 * pulse_train_home_jog_unit: home return with trapezoid ramp and jog output for two channels' pin map.
 * assumes controller logic presents a steady parameter set and pulses the start strobes;
 * home and near-home pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`include "pulse_home_jog_consts.vh"

// How it works
// R1: home done clears elapsed count to zero
// R2: controller keeps ramp time above steps*1000/f0
// R3: ramp time rounded up to step unit
// R4: controller keeps ramp time in legal range
// R5: frequency codes select legal hertz ranges
// R6: controller keeps ramped initial speed under 30kHz
// R7: clear output lasts programmed 0.5..100 ms
// R8: clear output on pin 2 or 5
// R9: controller picks quarter duty above 50 Hz
// R10: quarter duty recommended for ranges 1, 2
// R11: type one accepts home input anytime
// R12: type two waits for deceleration end
// R13: pulse out, near-home slows, home stops
// R14: controller enables near-home via control word
// R15: plain jog runs while trigger held
// R16: target jog stops at absolute target
// R17: no-count jog ignores target value
// R18: controller gives target on correct side
// R19: controller keeps first counting jog under 30kHz
// R20: channel pins: forward on 0/3, reverse 1/4
// R21: controller stops jog via control word
// R22: elapsed count signed 32-bit two words
// R23: controller pulses 0x10 then 0 to enable
// R24: ramp frequency in equal steps
module pulse_train_home_jog_unit #(
	parameter MS_CYC = `MS_CYCLES,
	parameter HALF_MS_CYC = `HALF_MS_CYCLES
) (
	input wire clk,
	input wire srst,
	input wire channelSel,
	input wire homeStart,
	input wire jogTrigger,
	input wire forceStop,
	input wire nearHomeEnable,
	input wire homeType,
	input wire sixtySteps,
	input wire quarterDuty,
	input wire [1:0] freqRange,
	input wire [1:0] outMethod,
	input wire reverseDir,
	input wire jogTargetMode,
	input wire [31:0] initSpeed,
	input wire [31:0] maxSpeed,
	input wire [15:0] rampTimeMs,
	input wire [7:0] clearTimeSet,
	input wire [31:0] jogSpeed,
	input wire [31:0] targetValue,
	input wire loadElapsed,
	input wire [31:0] elapsedLoadValue,
	input wire homePin,
	input wire nearHomePin,
	output reg [5:0] outPins_r,
	output reg [15:0] elapsedLow_r,
	output reg [15:0] elapsedHigh_r,
	output reg busy_r,
	output reg homeDone_r
);
	localparam ST_IDLE = 3'd0;
	localparam ST_ACCEL = 3'd1;
	localparam ST_CRUISE = 3'd2;
	localparam ST_DECEL = 3'd3;
	localparam ST_CREEP = 3'd4;
	localparam ST_CLEAR = 3'd5;
	localparam ST_JOG = 3'd6;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [1:0] homeSync_r;
	reg [1:0] nearSync_r;
	reg nearArmed_r;
	reg [31:0] elapsed_r;
	reg [31:0] curFreq_r;
	reg [31:0] stepSize_r;
	reg [7:0] stepCount_r;
	reg [31:0] stepTimer_r;
	reg [31:0] stepCycles_r;
	reg [31:0] clearTimer_r;
	reg jogHold_r;
	reg pulseRun;
	reg [31:0] pulseFreq;
	wire pulseLevel;
	wire pulseDone;

	// the step unit in ms equals the step count, so one step lasts rounded time / steps ms
	function [15:0] round_ramp;
		input [15:0] t;
		input sixty;
		reg [15:0] unit;
		reg [15:0] q;
		begin
			unit = sixty ? `STEP_UNIT_60_MS : `STEP_UNIT_30_MS;
			q = (t + unit - 16'd1) / unit;
			if (q == 16'h0)
				q = 16'h1;
			round_ramp = q * unit;
		end
	endfunction

	// pin slots: role 0 forward, 1 reverse, 2 clear; channel 2 sits three pins up
	function [2:0] pin_slot;
		input ch;
		input [1:0] role;
		begin
			pin_slot = ch ? 3'd3 + {1'b0, role} : {1'b0, role};
		end
	endfunction

	// R5: clamp into the range code's limits
	function [31:0] clamp_freq;
		input [31:0] f;
		input [1:0] range;
		begin
			if (range == 2'd0 && f > `FREQ_RANGE0_MAX)
				clamp_freq = `FREQ_RANGE0_MAX;
			else if (range == 2'd0 && f < `FREQ_RANGE0_MIN)
				clamp_freq = `FREQ_RANGE0_MIN;
			else if (range != 2'd0 && f > `FREQ_RANGE12_MAX)
				clamp_freq = `FREQ_RANGE12_MAX;
			else if (range == 2'd2 && f < `FREQ_RANGE2_MIN)
				clamp_freq = `FREQ_RANGE2_MIN;
			else if (range != 2'd0 && f < `FREQ_RANGE1_MIN)
				clamp_freq = `FREQ_RANGE1_MIN;
			else
				clamp_freq = f;
		end
	endfunction

	wire homeSeen = homeSync_r[1];
	wire nearSeen = nearSync_r[1] && nearArmed_r;
	wire [7:0] steps = sixtySteps ? `STEPS_60 : `STEPS_30;
	wire [31:0] initF = clamp_freq(initSpeed, freqRange);
	wire [31:0] maxF = clamp_freq(maxSpeed, freqRange);
	wire [15:0] rampRounded = round_ramp(rampTimeMs, sixtySteps);
	wire [31:0] clearCycles = (clearTimeSet == 8'h0) ? HALF_MS_CYC :
		((clearTimeSet > `CLEAR_TIME_MAX) ? `CLEAR_TIME_MAX : clearTimeSet) * MS_CYC;
	wire countDown = reverseDir;
	wire stepTick = (stepTimer_r + 32'd1 >= stepCycles_r);

	// two flops before any reader; only the second stage is used
	always @(posedge clk) begin
		if (srst) begin
			homeSync_r <= 2'h0;
			nearSync_r <= 2'h0;
		end else begin
			homeSync_r <= {homeSync_r[0], homePin};
			nearSync_r <= {nearSync_r[0], nearHomePin};
		end
	end

	always @* begin
		state_nxt = state_r;
		pulseRun = 1'b0;
		pulseFreq = curFreq_r;
		case (state_r)
			ST_IDLE: begin
				if (homeStart)
					state_nxt = ST_ACCEL;
				else if (jogTrigger && !jogHold_r)
					state_nxt = ST_JOG;
			end
			ST_ACCEL, ST_CRUISE: begin
				pulseRun = 1'b1;
				// R11: type one takes home at any point of the run
				if (homeSeen && homeType == `HOME_TYPE1)
					state_nxt = ST_CLEAR;
				// R13: near-home starts the slowdown
				else if (nearSeen)
					state_nxt = ST_DECEL;
				else if (state_r == ST_ACCEL && stepTick && stepCount_r + 8'd1 >= steps)
					state_nxt = ST_CRUISE;
			end
			ST_DECEL: begin
				pulseRun = 1'b1;
				if (homeSeen && homeType == `HOME_TYPE1)
					state_nxt = ST_CLEAR;
				else if (stepTick && stepCount_r + 8'd1 >= steps)
					state_nxt = ST_CREEP;
			end
			ST_CREEP: begin
				pulseRun = 1'b1;
				// R12: type two only listens once the slowdown is over
				if (homeSeen)
					state_nxt = ST_CLEAR;
			end
			ST_CLEAR: begin
				// R7: clear output held for the programmed time
				if (clearTimer_r + 32'd1 >= clearCycles)
					state_nxt = ST_IDLE;
			end
			ST_JOG: begin
				pulseFreq = clamp_freq(jogSpeed, freqRange);
				pulseRun = 1'b1;
				// R15: output only while the trigger is held
				if (!jogTrigger)
					state_nxt = ST_IDLE;
				// R16: target mode ends on match; R17: otherwise target unused
				else if (jogTargetMode && elapsed_r == targetValue)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (forceStop && state_r != ST_CLEAR)
			state_nxt = ST_IDLE;
	end

	// the generator restarts at every state change, so each phase begins on a fresh period
	pulse_rate_gen pulse_rate_gen_inst (
		.clk(clk),
		.srst(srst),
		.run(pulseRun && state_nxt == state_r),
		.freqHz(pulseFreq),
		.rangeCode0(freqRange == 2'd0),
		.quarterDuty(quarterDuty),
		.pulseLevel_r(pulseLevel),
		.pulseDone_r(pulseDone)
	);

	always @(posedge clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
			nearArmed_r <= 1'b0;
			elapsed_r <= 32'h0;
			curFreq_r <= 32'h0;
			stepSize_r <= 32'h0;
			stepCount_r <= 8'h0;
			stepTimer_r <= 32'h0;
			stepCycles_r <= 32'h1;
			clearTimer_r <= 32'h0;
			jogHold_r <= 1'b0;
			outPins_r <= 6'h0;
			elapsedLow_r <= 16'h0;
			elapsedHigh_r <= 16'h0;
			busy_r <= 1'b0;
			homeDone_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			homeDone_r <= 1'b0;
			stepTimer_r <= stepTick ? 32'h0 : stepTimer_r + 32'd1;
			if (state_r == ST_IDLE && state_nxt == ST_ACCEL) begin
				curFreq_r <= initF;
				// R24: equal frequency steps over the ramp
				stepSize_r <= (maxF > initF) ? (maxF - initF) / steps : 32'h0;
				// R3: step length from the rounded ramp time
				stepCycles_r <= (rampRounded / steps) * MS_CYC;
				stepCount_r <= 8'h0;
				stepTimer_r <= 32'h0;
			end else if (state_nxt != state_r) begin
				stepCount_r <= 8'h0;
				stepTimer_r <= 32'h0;
			end else if (stepTick && (state_r == ST_ACCEL || state_r == ST_DECEL)) begin
				stepCount_r <= stepCount_r + 8'd1;
				curFreq_r <= (state_r == ST_ACCEL) ? curFreq_r + stepSize_r :
					((curFreq_r > initF + stepSize_r) ? curFreq_r - stepSize_r : initF);
			end
			if (state_r == ST_CRUISE && state_nxt == ST_CRUISE)
				curFreq_r <= maxF;
			clearTimer_r <= (state_r == ST_CLEAR) ? clearTimer_r + 32'd1 : 32'h0;
			if (loadElapsed && state_r == ST_IDLE)
				elapsed_r <= elapsedLoadValue;
			else if (pulseDone)
				elapsed_r <= countDown ? elapsed_r - 32'd1 : elapsed_r + 32'd1;
			// R1: home completion zeroes the elapsed count
			if (state_r == ST_CLEAR && state_nxt == ST_IDLE) begin
				elapsed_r <= 32'h0;
				homeDone_r <= 1'b1;
				nearArmed_r <= 1'b0;
			end
			// a re-arm in the completing cycle wins over the disarm
			if (nearHomeEnable)
				nearArmed_r <= 1'b1;
			// a stop while the trigger is held stays until release, so it cannot restart
			if (!jogTrigger)
				jogHold_r <= 1'b0;
			else if (state_r == ST_JOG && state_nxt == ST_IDLE)
				jogHold_r <= 1'b1;
			// R22: signed value kept as two 16-bit words
			elapsedLow_r <= elapsed_r[15:0];
			elapsedHigh_r <= elapsed_r[31:16];
			busy_r <= (state_nxt != ST_IDLE);
			// R20: CW/CCW puts forward on 0/3, reverse on 1/4; the pulse/direction methods put pulses on 0/3, direction on 1/4
			outPins_r <= 6'h0;
			if (outMethod == `OUT_CW_CCW) begin
				outPins_r[pin_slot(channelSel, {1'b0, reverseDir})] <= pulseLevel;
			end else begin
				outPins_r[pin_slot(channelSel, 2'd0)] <= pulseLevel;
				outPins_r[pin_slot(channelSel, 2'd1)] <= (outMethod == `OUT_PD_REVON) ? reverseDir : !reverseDir;
			end
			// R8: clear signal on pin 2 or pin 5
			if (state_nxt == ST_CLEAR)
				outPins_r[pin_slot(channelSel, 2'd2)] <= 1'b1;
		end
	end
endmodule

//--- pulse_home_jog_consts.vh
/*
 * constants for the home return / jog pulse unit: timing counts, field codes.
 * assumes a 200 MHz system clock; included by the unit's design files.
 */
`ifndef PULSE_HOME_JOG_CONSTS_VH
`define PULSE_HOME_JOG_CONSTS_VH

`define CLK_HZ 200000000
`define MS_CYCLES 200000
`define HALF_MS_CYCLES 100000
`define STEP_UNIT_30_MS 16'd30
`define STEP_UNIT_60_MS 16'd60
`define STEPS_30 8'd30
`define STEPS_60 8'd60
`define CLEAR_TIME_MAX 8'd100
`define FREQ_RANGE0_MAX 32'd9800
`define FREQ_RANGE12_MAX 32'd100000
`define FREQ_RANGE0_LOW_HZ_X2 32'd3
`define FREQ_RANGE0_MIN 32'd1
`define FREQ_RANGE1_MIN 32'd48
`define FREQ_RANGE2_MIN 32'd191
`define OUT_CW_CCW 2'd0
`define OUT_PD_REVON 2'd2
`define OUT_PD_FWDON 2'd3
`define HOME_TYPE1 1'b0
`define HOME_TYPE2 1'b1

`endif

//--- pulse_rate_gen.v
/*
 * pulse_rate_gen: turns a frequency in hertz into a pulse train with 50% or 25% on width.
 * assumes freq is held steady by the caller between updates; one clock, sync reset.
 */
`timescale 1ns/1ps
`include "pulse_home_jog_consts.vh"

module pulse_rate_gen #(
	parameter CLK_FREQ = `CLK_HZ
) (
	input wire clk,
	input wire srst,
	input wire run,
	input wire [31:0] freqHz,
	input wire rangeCode0,
	input wire quarterDuty,
	output reg pulseLevel_r,
	output reg pulseDone_r
);
	reg [31:0] acc_r;
	reg [1:0] phase_r;
	reg [32:0] sum;
	reg [31:0] effFreq;

	// setting 1 in range 0 means 1.5 Hz, so the accumulator runs at 1.5 times the 1 Hz rate
	always @* begin
		if (rangeCode0 && freqHz == 32'd1)
			effFreq = `FREQ_RANGE0_LOW_HZ_X2;
		else
			effFreq = {freqHz[30:0], 1'b0};
		sum = {1'b0, acc_r} + {effFreq, 1'b0};
	end

	// four phases per period give both duty settings from one accumulator
	always @(posedge clk) begin
		if (srst) begin
			acc_r <= 32'h0;
			phase_r <= 2'h0;
			pulseLevel_r <= 1'b0;
			pulseDone_r <= 1'b0;
		end else begin
			pulseDone_r <= 1'b0;
			if (!run) begin
				acc_r <= 32'h0;
				phase_r <= 2'h0;
				pulseLevel_r <= 1'b0;
			end else if (sum >= CLK_FREQ) begin
				acc_r <= sum[31:0] - CLK_FREQ;
				phase_r <= phase_r + 2'h1;
				pulseLevel_r <= quarterDuty ? (phase_r == 2'h3) : phase_r[1] ^ 1'b1 ? 1'b0 : 1'b1;
				if (phase_r == 2'h3)
					pulseDone_r <= 1'b1;
			end else begin
				acc_r <= sum[31:0];
			end
		end
	end
endmodule

//--- home_jog_sva.sv
/* assertion checker for the home return / jog pulse unit
 * bound to the unit's top module; sees its ports only */
`timescale 1ns/1ps
module home_jog_sva #(
	parameter MS_CYC = 200000,
	parameter HALF_MS_CYC = 100000
) (
	input wire clk,
	input wire srst,
	input wire channelSel,
	input wire [1:0] outMethod,
	input wire reverseDir,
	input wire [7:0] clearTimeSet,
	input wire [5:0] outPins_r,
	input wire [15:0] elapsedLow_r,
	input wire [15:0] elapsedHigh_r,
	input wire busy_r,
	input wire homeDone_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire clr = outPins_r[2] | outPins_r[5];
	wire [31:0] want = clearTimeSet == 8'h00 ? HALF_MS_CYC : (clearTimeSet > 8'h64 ? 8'h64 : clearTimeSet) * MS_CYC;
	reg [31:0] hiCnt_r;
	// width of the clear pulse, judged when it drops
	always @(posedge clk) begin
		hiCnt_r <= (srst || !clr) ? 32'h0 : hiCnt_r + 32'h1;
	end
	property p_clrWidth; $fell(clr) |-> hiCnt_r + HALF_MS_CYC >= want && hiCnt_r <= want + HALF_MS_CYC; endproperty
	a_clrWidth: assert property (p_clrWidth) else $error("clear pulse width off");
	property p_doneOne; homeDone_r |=> !homeDone_r; endproperty
	a_doneOne: assert property (p_doneOne) else $error("done pulse too long");
	property p_zero; homeDone_r |-> ##[1:2] (elapsedLow_r == 16'h0000 && elapsedHigh_r == 16'h0000); endproperty
	a_zero: assert property (p_zero) else $error("count not cleared at home");
	property p_doneClr; $fell(clr) |-> ##[0:2] homeDone_r; endproperty
	a_doneClr: assert property (p_doneClr) else $error("no done after clear");
	property p_idle; homeDone_r |-> ##[0:2] !busy_r; endproperty
	a_idle: assert property (p_idle) else $error("busy after home done");
	property p_ch0; busy_r && !channelSel && $past(!channelSel) |-> outPins_r[5:3] == 3'h0; endproperty
	a_ch0: assert property (p_ch0) else $error("wrong channel pins");
	property p_dir; busy_r && outMethod == 2'h0 && reverseDir && $past(reverseDir) |-> !outPins_r[0] && !outPins_r[3]; endproperty
	a_dir: assert property (p_dir) else $error("forward pulse in reverse");
	property p_quiet; outMethod == 2'h0 && !busy_r && !$past(busy_r) |-> outPins_r == 6'h00; endproperty
	a_quiet: assert property (p_quiet) else $error("pins active while idle");
	c_done: cover property (homeDone_r);
	c_clr: cover property ($fell(clr));
	c_rev2: cover property (busy_r && outPins_r[4]);
endmodule
bind pulse_train_home_jog_unit home_jog_sva #(.MS_CYC(MS_CYC), .HALF_MS_CYC(HALF_MS_CYC)) home_jog_sva_inst (.clk, .srst,
	.channelSel, .outMethod, .reverseDir, .clearTimeSet, .outPins_r, .elapsedLow_r, .elapsedHigh_r, .busy_r, .homeDone_r);

//--- drive_model.sv
/* motor drive stand-in: counts pulses of the chosen channel and works the home sensors
 * assumes CW/REVERSE_PULSE_OUTPUT wiring; clr restarts counts and sensors */
`timescale 1ns/1ps
module drive_model (
	input wire clk,
	input wire clr,
	input wire chan,
	input wire [5:0] pins,
	input wire [15:0] nearAt,
	input wire [15:0] homeAt,
	output reg nearHome_r,
	output wire homeLevel,
	output reg [15:0] fwdCnt_r,
	output reg [15:0] revCnt_r
);
	reg [1:0] last_r;
	reg [7:0] blip_r;
	wire [1:0] now = chan ? pins[4:3] : pins[1:0];
	always @(posedge clk) begin
		last_r <= now;
		if (clr) begin
			fwdCnt_r <= 16'h0000;
			revCnt_r <= 16'h0000;
			nearHome_r <= 1'b0;
			blip_r <= 8'h00;
		end else begin
			fwdCnt_r <= fwdCnt_r + {15'h0000, now[0] & ~last_r[0]};
			revCnt_r <= revCnt_r + {15'h0000, now[1] & ~last_r[1]};
			if (!nearHome_r && fwdCnt_r + revCnt_r == nearAt) begin
				nearHome_r <= 1'b1;
				// short home flash: over before any slow-down can end
				blip_r <= 8'h64;
			end else if (blip_r != 8'h00) begin
				blip_r <= blip_r - 8'h01;
			end
		end
	end
	assign homeLevel = blip_r != 8'h00 || (nearHome_r && fwdCnt_r + revCnt_r >= homeAt);
endmodule

//--- pulse_train_home_jog_unit_test.sv
/* self-checking bench for the home return / jog pulse unit
 * inputs change at falling edges; a drive model answers on the pins */
`timescale 1ns/1ps
module pulse_train_home_jog_unit_test;
	reg clk = 1'b0, srst = 1'b1, channelSel = 1'b0, homeStart = 1'b0, jogTrigger = 1'b0, forceStop = 1'b0;
	reg nearHomeEnable = 1'b0, homeType = 1'b0, sixtySteps = 1'b0, quarterDuty = 1'b1, reverseDir = 1'b0;
	reg jogTargetMode = 1'b0, loadElapsed = 1'b0, mClr = 1'b1, seenClr = 1'b0;
	reg [1:0] freqRange = 2'h1, outMethod = 2'h0;
	reg [31:0] initSpeed = 32'h7530, maxSpeed = 32'h186a0, jogSpeed = 32'h0, targetValue = 32'h0, elapsedLoadValue = 32'h0;
	reg [15:0] rampTimeMs = 16'h1f, nearAt = 16'hffff, homeAt = 16'hffff;
	reg [7:0] clearTimeSet = 8'h00;
	wire homePin, nearHomePin, busy_r, homeDone_r;
	wire [5:0] outPins_r;
	wire [15:0] elapsedLow_r, elapsedHigh_r, fwdCnt, revCnt;
	integer err_count = 0, num_checks = 0, cyc = 0, i = 0, n = 0;
	pulse_train_home_jog_unit #(.MS_CYC(20), .HALF_MS_CYC(10)) pulse_train_home_jog_unit_inst (.clk, .srst, .channelSel,
		.homeStart, .jogTrigger, .forceStop, .nearHomeEnable, .homeType, .sixtySteps, .quarterDuty, .freqRange, .outMethod,
		.reverseDir, .jogTargetMode, .initSpeed, .maxSpeed, .rampTimeMs, .clearTimeSet, .jogSpeed, .targetValue, .loadElapsed,
		.elapsedLoadValue, .homePin, .nearHomePin, .outPins_r, .elapsedLow_r, .elapsedHigh_r, .busy_r, .homeDone_r);
	drive_model drive_model_inst (.clk, .clr(mClr), .chan(channelSel), .pins(outPins_r), .nearAt, .homeAt,
		.nearHome_r(nearHomePin), .homeLevel(homePin), .fwdCnt_r(fwdCnt), .revCnt_r(revCnt));
	initial forever #2.5 clk = ~clk;
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task final_report;
		if (err_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// a hung wait still reaches the verdict
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			err_count = err_count + 1;
			final_report;
		end
	end
	task waitBusy(input logic v, input integer lim);
		i = 0;
		while (busy_r !== v && i < lim) begin
			@(negedge clk);
			i = i + 1;
		end
	endtask
	task prep(input logic ch, input logic rv, input logic [31:0] start);
		@(negedge clk);
		channelSel = ch;
		reverseDir = rv;
		elapsedLoadValue = start;
		loadElapsed = 1'b1;
		mClr = 1'b1;
		@(negedge clk);
		loadElapsed = 1'b0;
		mClr = 1'b0;
	endtask
	task jogTo(input logic ch, input logic rv, input logic [31:0] spd, input logic [31:0] start, input logic [31:0] tgt,
		input logic [15:0] cnt);
		prep(ch, rv, start);
		jogSpeed = spd;
		targetValue = tgt;
		jogTargetMode = 1'b1;
		jogTrigger = 1'b1;
		waitBusy(1'b1, 4);
		waitBusy(1'b0, 30000);
		jogTrigger = 1'b0;
		repeat (3) @(negedge clk);
		chk("target stop", busy_r, 32'h0);
		chk("count", {elapsedHigh_r, elapsedLow_r}, tgt);
		chk("pulses", rv ? revCnt : fwdCnt, cnt);
		chk("wrong pin", rv ? fwdCnt : revCnt, 32'h0);
	endtask
	task plainJog(input logic [1:0] rng, input integer hold, input logic [15:0] lo, input logic [15:0] hi);
		prep(1'b0, 1'b0, 32'h0);
		freqRange = rng;
		jogSpeed = 32'h186a0;
		targetValue = 32'h1;
		jogTargetMode = 1'b0;
		jogTrigger = 1'b1;
		repeat (hold) @(negedge clk);
		chk("jog running", busy_r, 32'h1);
		jogTrigger = 1'b0;
		waitBusy(1'b0, 21000);
		chk("jog stopped", busy_r, 32'h0);
		chk("jog pulses", fwdCnt >= lo && fwdCnt <= hi, 32'h1);
	endtask
	task dirJog;
		prep(1'b0, 1'b1, 32'h0);
		outMethod = 2'h2;
		jogSpeed = 32'h186a0;
		jogTargetMode = 1'b0;
		jogTrigger = 1'b1;
		repeat (3000) @(negedge clk);
		chk("dir pin", outPins_r[1], 32'h1);
		chk("count down", {elapsedHigh_r, elapsedLow_r}, 32'hffffffff);
		// stop by control while the trigger is still held
		forceStop = 1'b1;
		@(negedge clk);
		chk("forced stop", busy_r, 32'h0);
		forceStop = 1'b0;
		jogTrigger = 1'b0;
		reverseDir = 1'b0;
		@(negedge clk);
		outMethod = 2'h0;
		@(negedge clk);
	endtask
	task homeRun(input logic t, input logic ch, input logic [31:0] f1, input logic [15:0] ms, input logic [7:0] ct);
		prep(ch, !ch, 32'h5);
		homeType = t;
		sixtySteps = t;
		maxSpeed = f1;
		rampTimeMs = ms;
		clearTimeSet = ct;
		nearAt = 16'h2;
		homeAt = t ? 16'h3 : 16'hffff;
		homeStart = 1'b1;
		@(negedge clk);
		homeStart = 1'b0;
		nearHomeEnable = 1'b1;
		@(negedge clk);
		nearHomeEnable = 1'b0;
		chk("home busy", busy_r, 32'h1);
		n = 0;
		while (!nearHomePin && n < 30000) begin
			@(negedge clk);
			n = n + 1;
		end
		n = 0;
		seenClr = 1'b0;
		while (homeDone_r !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n = n + 1;
			seenClr = seenClr | outPins_r[ch ? 5 : 2];
		end
		chk("home wait", t ? n > 1500 && n < 20000 : n < 300, 32'h1);
		chk("clear pin", seenClr, 32'h1);
		repeat (3) @(negedge clk);
		chk("count cleared", {elapsedHigh_r, elapsedLow_r}, 32'h0);
		chk("home idle", busy_r, 32'h0);
	endtask
	initial begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk("reset outputs", {outPins_r, busy_r, homeDone_r, elapsedHigh_r, elapsedLow_r}, 32'h0);
		// quarter duty kept at every speed
		// first counting jog at 30 kHz
		jogTo(1'b0, 1'b0, 32'h7530, 32'h0, 32'h2, 16'h2);
		jogTo(1'b1, 1'b1, 32'h186a0, 32'ha, 32'h7, 16'h3);
		plainJog(2'h2, 7000, 16'h2, 16'h4);
		plainJog(2'h0, 6000, 16'h0, 16'h1);
		freqRange = 2'h1;
		dirJog;
		// ramp above steps*1000/f0, in range, start at 30 kHz
		homeRun(1'b0, 1'b0, 32'h186a0, 16'h1f, 8'h00);
		homeRun(1'b1, 1'b1, 32'hea60, 16'h3d, 8'h02);
		final_report;
	end
endmodule
